// >>> hall_comp_top.sv
// Hall signal path: filter, gain and offset compensation, registers
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module hall_comp_top
   import hall_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic signed [15:0] adc_data,
   input wire logic adc_valid,
   input wire logic signed [7:0] temp_delta,
   output logic signed [15:0] comp_sample,
   output logic comp_valid,
   output logic chop_phase,
   output logic demod_strobe
);
   typedef struct packed {
      logic [7:0][31:0] regs;
      logic ack;
      logic [31:0] rdat;
      logic warm;
      logic signed [15:0] y1;
      logic signed [15:0] out;
      logic valid;
   } top_s;

   localparam top_s RST_S = '{
      regs: {32'h0, 32'h0, 32'h0, 32'h0, RST_TRIM, RST_INIT, 32'h0,
         RST_FILT},
      default: '0
   };

   top_s s;
   top_s next_s;
   filt_if fb();

   // ************************************************
   // Helpers
   // ************************************************
   // Clamp instead of wrap so a hot overflow cannot flip the sign
   function automatic logic signed [15:0] sat16(
      input logic signed [47:0] v
   );
      logic signed [15:0] r;
      r = v[15:0];
      if (v > 48'sh7fff) begin
         r = 16'sh7fff;
      end else if (v < -48'sh8000) begin
         r = -16'sh8000;
      end
      return r;
   endfunction

   // Writable bits per register; anything else reads zero, except the status word
   function automatic logic [31:0] reg_mask(input logic [5:0] idx);
      logic [31:0] m;
      m = '0;
      case (idx)
         6'(REG_FILT): m = MASK_FILT;
         6'(REG_INIT): m = MASK_INIT;
         6'(REG_TRIM): m = MASK_TRIM;
         6'(REG_SLOPE): m = MASK_SLOPE;
         6'(REG_CURV): m = MASK_CURV;
         6'(REG_QO): m = MASK_QO;
         6'(REG_QOTC): m = MASK_QOTC;
         default: m = '0;
      endcase
      return m;
   endfunction

   // ************************************************
   // Submodules
   // ************************************************
   assign fb.narrowest_bandwidth_code =
      s.regs[REG_FILT][NARROW_LSB +: CODE_W];
   assign fb.widest_bandwidth_code = s.regs[REG_FILT][WIDE_LSB +: CODE_W];
   assign fb.tracking_gain = s.regs[REG_FILT][GAIN_LSB +: CODE_W];
   assign fb.in_data = adc_data;
   assign fb.in_valid = adc_valid;

   hall_iir u_iir (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .fb(fb)
   );

   chop_timer u_chop (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .chop_phase(chop_phase),
      .demod_strobe(demod_strobe)
   );

   // ************************************************
   // Bus slave and compensation
   // ************************************************
   always_comb begin
      logic signed [47:0] p;
      logic signed [47:0] tc;
      logic signed [47:0] f;
      logic signed [10:0] c1;
      logic signed [9:0] c2;
      logic signed [11:0] ot;
      logic [31:0] m;
      logic req;
      p = '0;
      tc = '0;
      f = '0;
      c1 = '0;
      c2 = '0;
      ot = '0;
      m = reg_mask(adr_i[7:2]);
      req = cyc_i && stb_i;
      next_s = s;
      next_s.valid = 1'b0;
      // Ack one cycle after the request; write lands at the ack edge
      next_s.ack = req && !s.ack;
      if (req && !s.ack) begin
         if (adr_i[7:2] == 6'(REG_STATUS)) begin
            next_s.rdat = {12'h000, fb.code, s.out};
         end else begin
            next_s.rdat = s.regs[adr_i[4:2]] & m;
         end
      end
      // Unmapped indices alias a real slot through adr_i[4:2]; drop them
      if (req && s.ack && we_i) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b] && m != '0) begin
               next_s.regs[adr_i[4:2]][8*b +: 8] =
                  dat_i[8*b +: 8] & m[8*b +: 8];
            end
         end
      end
      if (fb.out_valid) begin
         next_s.warm = temp_delta >= 8'sh00;
         if (next_s.warm) begin
            c1 = $signed(s.regs[REG_SLOPE][SLOPE_W-1:0]);
            c2 = $signed(s.regs[REG_CURV][CURV_W-1:0]);
            ot = $signed(s.regs[REG_QOTC][QOTC_W-1:0]);
         end else begin
            c1 = $signed(s.regs[REG_SLOPE][SLOPE_COOL_LSB +: SLOPE_W]);
            c2 = $signed(s.regs[REG_CURV][CURV_COOL_LSB +: CURV_W]);
            ot = $signed(s.regs[REG_QOTC][QOTC_COOL_LSB +: QOTC_W]);
         end
         // Temperature term, slope in 1/256 %/C, kept in Q16
         tc = ((48'(c2) * 48'(temp_delta) * 48'(DIV1000_MUL))
            >>> DIV1000_SH) + 48'(c1);
         f = (48'sh1 <<< TC_FRAC) +
            ((tc * 48'(temp_delta) * 48'(PCT_MUL)) >>> PCT_SH);
         p = 48'(fb.out_data) *
            $signed(48'(s.regs[REG_INIT][INIT_W-1:0]));
         p = 48'(sat16(p >>> INIT_FRAC));
         if (s.regs[REG_TRIM][POL_BIT]) begin
            p = -p;
         end
         p = 48'(sat16(p * ($signed(48'(
            s.regs[REG_TRIM][CRS_LSB +: CRS_W])) + 48'sh1)));
         p = 48'(sat16((p * $signed(48'(s.regs[REG_TRIM][FINE_W-1:0])))
            >>> FINE_FRAC));
         next_s.y1 = sat16((p * f) >>> TC_FRAC);
         // Offset only after the gain result is final
         next_s.out = sat16(48'(next_s.y1) +
            48'($signed(s.regs[REG_QO][QO_W-1:0])) +
            48'(ot) * 48'(temp_delta));
         next_s.valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= RST_S;
      end else begin
         s <= next_s;
      end
   end

   assign dat_o = s.rdat;
   assign ack_o = s.ack;
   assign comp_sample = s.out;
   assign comp_valid = s.valid;

   // ************************************************
   // Checks
   // ************************************************
   logic unity;
   logic no_offset;
   assign no_offset = s.regs[REG_QO] == '0 && s.regs[REG_QOTC] == '0;
   assign unity = no_offset && s.regs[REG_INIT] == RST_INIT &&
      s.regs[REG_TRIM] == RST_TRIM && s.regs[REG_SLOPE] == '0 &&
      s.regs[REG_CURV] == '0;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_ack_single:
   assert property (ack_o |=> !ack_o)
      else $error("ack held for more than one cycle");
   chk_comp_latency:
   assert property (fb.out_valid |=> comp_valid ##1 !comp_valid ||
      $past(fb.out_valid, 1))
      else $error("compensated sample not one cycle after filter");
   chk_unity_path:
   assert property (fb.out_valid && unity |=>
      comp_sample == $past(fb.out_data))
      else $error("unity gain path altered the sample");
   chk_region_select:
   assert property (fb.out_valid |=> s.warm == ($past(temp_delta) >= 0))
      else $error("wrong temperature region chosen");
   chk_offset_after:
   assert property (fb.out_valid && no_offset |=> comp_sample == s.y1)
      else $error("offset applied with zero trims");
   chk_sat_high:
   assert property (fb.out_valid && s.regs[REG_QOTC] == '0 &&
      s.regs[REG_QO][QO_W-1:0] == 18'h1ffff |=>
      comp_sample == 16'sh7fff)
      else $error("offset sum wrapped instead of saturating");
   chk_status_read:
   assert property (cyc_i && stb_i && !ack_o && !we_i &&
      adr_i[7:2] == 6'(REG_STATUS) |=> ack_o && dat_o[15:0] ==
      $past(comp_sample))
      else $error("status read does not show last sample");
   cov_cool_sample: cover property (fb.out_valid && temp_delta < 0);
   cov_saturated: cover property (comp_valid && comp_sample == 16'sh7fff);
endmodule

// >>> hall_pkg.sv
// Constants shared by the Hall filter and compensation path
//
// Summary of operation
// - Field samples pass an IIR low-pass set by the bandwidth code.
// - Adaptive mode keeps the code between widest and narrowest settings.
// - Tracking gain zero gives a fixed IIR at the narrowest code.
// - Higher tracking gain widens sooner: faster, noisier; lower is quieter.
// - Samples are signed values that are scaled, offset and compensated.
// - Gain correction is applied first, offset correction after it.
// - Warm coefficients at or above 25 C, cool ones below.
// - Warm slope and curvature are independent of the cool ones.
// - Gain = init x polarity x coarse x fine x (1 + temperature term).
// - Gain stage hands a 16-bit signed value to the offset stage.
// - Offset stage adds offset trim plus region offset slope times dT.
// - Final result leaves as a 16-bit signed sample.
// - Chopper runs at 64 kHz, demodulation strobes at twice that.
// - Gain trim: polarity bit 15, coarse 14:12, fine 10:0.
// - Gain slopes 11 bits: warm 10:0, cool 22:12.
// - Gain curvatures 10 bits: warm 9:0, cool 21:12.
// - Quiescent offset trim is 18 bits at 17:0.
package hall_pkg;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int CHOP_HZ = 64_000;
   localparam int CHOP_HALF = CLK_HZ / (2 * CHOP_HZ);
   localparam int CHOP_CNT_W = 9;
   // ************************************************
   // Register indices, byte address is four times
   // ************************************************
   localparam int REG_FILT = 0;
   localparam int REG_STATUS = 1;
   localparam int REG_INIT = 2;
   localparam int REG_TRIM = 3;
   localparam int REG_SLOPE = 4;
   localparam int REG_CURV = 5;
   localparam int REG_QO = 6;
   localparam int REG_QOTC = 7;
   localparam logic [31:0] MASK_FILT = 32'h0000_0fff;
   localparam logic [31:0] MASK_INIT = 32'h0000_ffff;
   localparam logic [31:0] MASK_TRIM = 32'h0000_f7ff;
   localparam logic [31:0] MASK_SLOPE = 32'h007f_f7ff;
   localparam logic [31:0] MASK_CURV = 32'h003f_f3ff;
   localparam logic [31:0] MASK_QO = 32'h0003_ffff;
   localparam logic [31:0] MASK_QOTC = 32'h00ff_ffff;
   localparam logic [31:0] RST_FILT = 32'h0000_0028;
   localparam logic [31:0] RST_INIT = 32'h0000_1000;
   localparam logic [31:0] RST_TRIM = 32'h0000_0400;
   // ************************************************
   // Field layout
   // ************************************************
   localparam int CODE_W = 4;
   localparam int NARROW_LSB = 0;
   localparam int WIDE_LSB = 4;
   localparam int GAIN_LSB = 8;
   localparam int INIT_W = 16;
   localparam int POL_BIT = 15;
   localparam int CRS_LSB = 12;
   localparam int CRS_W = 3;
   localparam int FINE_W = 11;
   localparam int SLOPE_W = 11;
   localparam int SLOPE_COOL_LSB = 12;
   localparam int CURV_W = 10;
   localparam int CURV_COOL_LSB = 12;
   localparam int QO_W = 18;
   localparam int QOTC_W = 12;
   localparam int QOTC_COOL_LSB = 12;
   // ************************************************
   // Arithmetic scaling
   // ************************************************
   localparam int INIT_FRAC = 12;
   localparam int FINE_FRAC = 10;
   localparam int TC_FRAC = 16;
   localparam int DIV1000_MUL = 1049;
   localparam int DIV1000_SH = 20;
   localparam int PCT_MUL = 655;
   localparam int PCT_SH = 8;
   localparam int ACC_FRAC = 16;
   localparam logic [15:0] ADAPT_THRESH = 16'h0800;
endpackage

// >>> filt_if.sv
// Link between the register side and the IIR filter
`timescale 1ns/1ns
interface filt_if;
   logic [3:0] narrowest_bandwidth_code;
   logic [3:0] widest_bandwidth_code;
   logic [3:0] tracking_gain;
   logic signed [15:0] in_data;
   logic in_valid;
   logic signed [15:0] out_data;
   logic out_valid;
   logic [3:0] code;
   modport filt (input narrowest_bandwidth_code, widest_bandwidth_code,
      tracking_gain, in_data, in_valid, output out_data, out_valid, code);
   modport ctl (output narrowest_bandwidth_code, widest_bandwidth_code,
      tracking_gain, in_data, in_valid, input out_data, out_valid, code);
endinterface

// >>> chop_timer.sv
// Chopper phase and demodulation strobe divider
`timescale 1ns/1ns
module chop_timer
   import hall_pkg::*;
#(
   parameter int HALF = CHOP_HALF
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic chop_phase,
   output logic demod_strobe
);
   localparam logic [CHOP_CNT_W-1:0] LAST = CHOP_CNT_W'(HALF - 1);
   typedef struct packed {
      logic [CHOP_CNT_W-1:0] cnt;
      logic phase;
      logic strobe;
   } chop_s;
   chop_s s;
   chop_s next_s;

   always_comb begin
      next_s = s;
      next_s.strobe = 1'b0;
      if (s.cnt == LAST) begin
         next_s.cnt = '0;
         next_s.phase = !s.phase;
         next_s.strobe = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign chop_phase = s.phase;
   assign demod_strobe = s.strobe;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_chop_toggle:
   assert property (demod_strobe |-> chop_phase != $past(chop_phase))
      else $error("chop phase did not toggle with strobe");
   chk_chop_period:
   assert property (demod_strobe |-> $past(s.cnt) == LAST && s.cnt == '0)
      else $error("demodulation strobe off its period");
endmodule

// >>> hall_iir.sv
// Adaptive-bandwidth IIR low-pass for the field samples
`timescale 1ns/1ns
module hall_iir
   import hall_pkg::*;
#(
   parameter logic [15:0] THRESH = ADAPT_THRESH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   filt_if.filt fb
);
   typedef struct packed {
      logic signed [31:0] acc;
      logic [3:0] code;
      logic signed [15:0] out;
      logic valid;
   } iir_s;
   iir_s s;
   iir_s next_s;
   logic signed [32:0] err;
   logic [32:0] mag;
   logic big;

   // Large step against the smoothed value asks for a wider band
   assign err = (33'(fb.in_data) <<< ACC_FRAC) - 33'(s.acc);
   assign mag = err[32] ? 33'(-err) : 33'(err);
   assign big = mag[32:ACC_FRAC] > {1'b0, THRESH >> fb.tracking_gain};

   always_comb begin
      logic [3:0] cand;
      cand = s.code;
      next_s = s;
      next_s.valid = 1'b0;
      if (fb.in_valid) begin
         if (fb.tracking_gain == '0) begin
            cand = fb.narrowest_bandwidth_code;
         end else if (big) begin
            cand = (s.code > fb.widest_bandwidth_code) ?
               s.code - 1'b1 : fb.widest_bandwidth_code;
         end else begin
            // Recover one step per sample: gain sets how soon we widen
            cand = (s.code < fb.narrowest_bandwidth_code) ?
               s.code + 1'b1 : fb.narrowest_bandwidth_code;
         end
         if (cand > fb.narrowest_bandwidth_code) begin
            cand = fb.narrowest_bandwidth_code;
         end
         if (cand < fb.widest_bandwidth_code) begin
            cand = fb.widest_bandwidth_code;
         end
         next_s.code = cand;
         next_s.acc = 32'(33'(s.acc) + (err >>> cand));
         next_s.out = next_s.acc[31:ACC_FRAC];
         next_s.valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign fb.out_data = s.out;
   assign fb.out_valid = s.valid;
   assign fb.code = s.code;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_filt_latency:
   assert property (fb.in_valid |=> fb.out_valid)
      else $error("filter output did not follow its input");
   chk_fixed_code:
   assert property (fb.in_valid && fb.tracking_gain == '0 |=>
      fb.code == $past(fb.narrowest_bandwidth_code))
      else $error("fixed filter not at narrowest code");
   chk_code_bounds:
   assert property (fb.in_valid && fb.widest_bandwidth_code <=
      fb.narrowest_bandwidth_code |=>
      fb.code >= $past(fb.widest_bandwidth_code) &&
      fb.code <= $past(fb.narrowest_bandwidth_code))
      else $error("adaptive code out of bounds");
   chk_adapt_widen:
   assert property (fb.in_valid && fb.tracking_gain != '0 && big &&
      s.code > fb.widest_bandwidth_code &&
      s.code <= fb.narrowest_bandwidth_code |=>
      fb.code == $past(s.code) - 1'b1)
      else $error("adaptive filter did not widen");
   cov_widen: cover property (fb.in_valid && fb.tracking_gain != '0 && big);
endmodule

// >>> hall_front_model.sv
// Behavioural converter front end that hands field samples to the block
`timescale 1ns/1ns
module hall_front_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic send,
   input wire logic slow,
   input wire logic signed [15:0] value,
   output logic signed [15:0] adc_data,
   output logic adc_valid
);
   // ************************************************
   // Conversion pipeline
   // ************************************************
   logic [3:0] vld = 4'h0;
   logic signed [15:0] dly [4] = '{default: 16'sh0000};
   logic signed [15:0] tap;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         vld <= 4'h0;
      end else begin
         vld <= {vld[2:0], send};
      end
      dly[0] <= value;
      dly[1] <= dly[0];
      dly[2] <= dly[1];
      dly[3] <= dly[2];
   end
   // Slow mode answers three cycles late; only switch it while idle
   always_comb begin
      tap = slow ? dly[3] : dly[0];
      adc_valid = slow ? vld[3] : vld[0];
      // Off a valid cycle the lines show the inverse, never the sample
      adc_data = adc_valid ? tap : ~tap;
   end
endmodule

// >>> tb.sv
// Self-checking bench for the Hall filter and compensation path
`timescale 1ns/1ns
module tb
   import hall_pkg::*;
;
   typedef struct {
      int trim, init, slope, curv, qo, qotc, t, x, e, tol;
   } row_s;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o, rd;
   logic ack_o, adc_valid, comp_valid, chop_phase, demod_strobe, ph;
   logic signed [15:0] adc_data, comp_sample;
   logic signed [15:0] value = 16'sh0000;
   logic signed [7:0] temp_delta = 8'sh00;
   logic send = 1'b0, slow = 1'b0;
   logic signed [15:0] q [$];
   int err_count = 0, checks_done = 0, c;
   // Active slope and curvature cases allow a few LSB of fixed-point rounding
   row_s rows [22] = '{
      '{16'h0400, 16'h1000, 0, 0, 0, 0, 0, 1234, 1234, 0},
      '{16'h8400, 16'h1000, 0, 0, 0, 0, 0, 1234, -1234, 0},
      '{16'h1400, 16'h1000, 0, 0, 0, 0, 0, 1000, 2000, 0},
      '{16'h7400, 16'h1000, 0, 0, 0, 0, 0, 1000, 8000, 0},
      '{16'h0200, 16'h1000, 0, 0, 0, 0, 0, 1000, 500, 0},
      '{16'h0400, 16'h2000, 0, 0, 0, 0, 0, 1000, 2000, 0},
      '{16'h1400, 16'h1000, 0, 0, 0, 0, 0, 30000, 32767, 0},
      '{16'h1400, 16'h1000, 0, 0, 0, 0, 0, -30000, -32768, 0},
      '{16'h0400, 16'h1000, 0, 0, 100, 0, 0, 1000, 1100, 0},
      '{16'h0400, 16'h1000, 0, 0, 18'h3ff9c, 0, 0, 1000, 900, 0},
      '{16'h1400, 16'h1000, 0, 0, 100, 0, 0, 1000, 2100, 0},
      '{16'h0400, 16'h1000, 0, 0, 2000, 0, 0, 32000, 32767, 0},
      '{16'h0400, 16'h1000, 24'h000100, 0, 0, 0, 10, 1000, 1100, 3},
      '{16'h0400, 16'h1000, 24'h000100, 0, 0, 0, -10, 1000, 1000, 0},
      '{16'h0400, 16'h1000, 24'h100000, 0, 0, 0, -10, 1000, 900, 3},
      '{16'h0400, 16'h1000, 24'h100000, 0, 0, 0, 10, 1000, 1000, 0},
      '{16'h0400, 16'h1000, 0, 24'h000100, 0, 0, 100, 1000, 1100, 3},
      '{16'h0400, 16'h1000, 0, 24'h100000, 0, 0, -100, 1000, 1100, 3},
      '{16'h0400, 16'h1000, 0, 0, 0, 24'h000005, 10, 1000, 1050, 0},
      '{16'h0400, 16'h1000, 0, 0, 0, 24'hffd000, -10, 1000, 1030, 0},
      '{16'h0400, 16'h1000, 0, 0, 18'h1ffff, 0, 0, 1000, 32767, 0},
      '{16'h0400, 16'h1000, 0, 0, 0, 0, 0, 1000, 1000, 0}
   };
   always #10 clk_sys = ~clk_sys;
   hall_comp_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .adc_data(adc_data),
      .adc_valid(adc_valid), .temp_delta(temp_delta),
      .comp_sample(comp_sample), .comp_valid(comp_valid),
      .chop_phase(chop_phase), .demod_strobe(demod_strobe));
   hall_front_model u_adc (.clk_sys(clk_sys), .rst_n(rst_n), .send(send),
      .slow(slow), .value(value), .adc_data(adc_data),
      .adc_valid(adc_valid));
   // ************************************************
   // Reporting and bus tasks
   // ************************************************
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic timeout(input string n);
      err_count++;
      $display("mismatch %s expected answer seen none", n);
      summarize();
   endtask
   task automatic cmp32(input string n, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmps(input string n, input int e, input int tol,
         input logic signed [15:0] g);
      int d;
      checks_done++;
      d = int'(g) - e;
      if ((^g === 1'bx) || d > tol || d < -tol) begin
         err_count++;
         $display("mismatch %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge clk_sys);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         if (ack_o === 1'b1) break;
      end
      if (k == 50) timeout("ack");
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [31:0] d);
      wb(1'b1, 8'(4 * i), d, 4'hf);
   endtask
   task automatic rdchk(input string n, input int i, input logic [31:0] e);
      wb(1'b0, 8'(4 * i), 32'h0, 4'h0);
      cmp32(n, e, rd);
   endtask
   task automatic code_chk(input string n, input int e);
      wb(1'b0, 8'(4 * REG_STATUS), 32'h0, 4'h0);
      cmp32(n, 32'(e), {28'h0, rd[19:16]});
   endtask
   // Back-to-back samples, outputs gathered in arrival order
   task automatic feed(input int n, input logic signed [15:0] v);
      int k;
      q.delete();
      for (k = 0; k < n + 20 && q.size() < n; k++) begin
         @(posedge clk_sys);
         if (comp_valid === 1'b1) q.push_back(comp_sample);
         send <= (k < n);
         value <= v;
      end
      if (q.size() < n) timeout("sample");
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      cmp32("rst flags", 32'h0,
         {28'h0, ack_o, comp_valid, chop_phase, demod_strobe});
      cmps("rst sample", 0, 0, comp_sample);
      rst_n <= 1'b1;
      rdchk("filt rst", REG_FILT, 32'h0000_0028);
   endtask
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      do_reset();
      rdchk("init rst", REG_INIT, 32'h0000_1000);
      rdchk("trim rst", REG_TRIM, 32'h0000_0400);
      wr(REG_TRIM, 32'hffff_ffff);
      rdchk("trim mask", REG_TRIM, 32'h0000_f7ff);
      wr(REG_SLOPE, 32'hffff_ffff);
      rdchk("slope mask", REG_SLOPE, 32'h007f_f7ff);
      wr(REG_CURV, 32'hffff_ffff);
      rdchk("curv mask", REG_CURV, 32'h003f_f3ff);
      wr(REG_QO, 32'hffff_ffff);
      rdchk("qo mask", REG_QO, 32'h0003_ffff);
      wb(1'b1, 8'h08, 32'hffff_ffff, 4'h1);
      rdchk("init lane", REG_INIT, 32'h0000_10ff);
      wr(60, 32'hffff_ffff);
      rdchk("unmapped", 60, 32'h0);
      rdchk("unmapped keep", REG_SLOPE, 32'h007f_f7ff);
      wr(REG_FILT, 32'h0);
      foreach (rows[i]) begin
         temp_delta <= 8'(rows[i].t);
         slow <= (i % 2 == 1);
         wr(REG_TRIM, rows[i].trim);
         wr(REG_INIT, rows[i].init);
         wr(REG_SLOPE, rows[i].slope);
         wr(REG_CURV, rows[i].curv);
         wr(REG_QO, rows[i].qo);
         wr(REG_QOTC, rows[i].qotc);
         feed(1, 16'(rows[i].x));
         cmps("row", rows[i].e, rows[i].tol, q[0]);
      end
      wr(REG_STATUS, 32'h0);
      rdchk("status", REG_STATUS, 32'h0000_03e8);
      feed(1, 16'sd0);
      wr(REG_FILT, 32'h0000_0011);
      feed(3, 16'sd1000);
      cmps("step 1", 500, 0, q[0]);
      cmps("step 2", 750, 0, q[1]);
      cmps("step 3", 875, 0, q[2]);
      wr(REG_FILT, 32'h0000_0428);
      feed(8, 16'sd20000);
      code_chk("code wide", 2);
      feed(60, 16'sd20000);
      code_chk("code narrow", 8);
      wr(REG_FILT, 32'h0000_0128);
      feed(4, 16'sd20500);
      code_chk("code gain1", 8);
      wr(REG_FILT, 32'h0000_0828);
      feed(4, 16'sd21000);
      code_chk("code gain8", 4);
      wr(REG_FILT, 32'h0000_0028);
      feed(8, -16'sd20000);
      code_chk("code fixed", 8);
      wr(REG_FILT, 32'h0000_0183);
      feed(2, 16'sd0);
      code_chk("code inverted", 8);
      for (c = 0; c < 1000 && demod_strobe !== 1'b1; c++) @(posedge clk_sys);
      if (c == 1000) timeout("strobe");
      ph = chop_phase;
      for (c = 1; c < 1000; c++) begin
         @(posedge clk_sys);
         if (demod_strobe === 1'b1) break;
      end
      cmp32("strobe gap", 32'(CLK_HZ / (2 * CHOP_HZ)), 32'(c));
      cmp32("phase flip", {31'h0, ~ph}, {31'h0, chop_phase});
      wr(REG_FILT, 32'h0000_0fff);
      do_reset();
      summarize();
   end
endmodule
